// file: hdl/ddc_chain.sv
// Overview of operation
// - stages take complex I/Q from the mixer; outputs are 15 bits each.
// - every stage is a linear-phase FIR, equal group delay for all frequencies.
// - bypass does no decimation, passing each accepted real 12-bit sample as one word.
// - factors 4/8/16/32 give one complex output per factor input samples.
// - composite response protects 0.8 of output rate, >90 dB stop, tiny ripple.
// - fixed stage order; each larger factor prepends the next earlier stage.
// - each stage decimates by exactly two and scales by its own power of two.
// - coefficients symmetric about one centre tap; only the outer half stored, centre is 2**(shift-1).
// - decimated 16-bit word: 15-bit data high, over-range flag a on I, b on Q in bit 0.
// - decimation factor, including bypass, comes from the link mode selection.
// - gain boost 1 gives 6.02 dB chain gain, 0 gives 0 dB.
`timescale 1ns/100ps
`default_nettype none

module ddc_fifo
	import ddc_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = DDC_FIFO_DEPTH
)(
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [WIDTH-1:0]      rd_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             do_wr, do_rd;

	assign wr_ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd_valid = (cnt_r != '0);
	assign rd_data  = mem[rd_ptr_r];
	assign do_wr    = wr_valid && wr_ready;
	assign do_rd    = rd_valid && rd_ready;

	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt    = cnt_r;
		if (do_wr)
			wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
		if (do_rd)
			rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
		if (do_wr && !do_rd)
			cnt_nxt = cnt_r + (AW+1)'(1);
		else if (do_rd && !do_wr)
			cnt_nxt = cnt_r - (AW+1)'(1);
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

	// storage needs no reset; the count gates every read
	always_ff @(posedge clk_sys)
	begin
		if (do_wr)
			mem[wr_ptr_r] <= wr_data;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_FIFO_FULL: assert property ((cnt_r == (AW+1)'(DEPTH)) |-> !wr_ready && rd_valid)
		else $error("fifo full but still accepting");
	AST_FIFO_CNT: assert property ((do_wr && !do_rd) |=> (cnt_r == $past(cnt_r) + (AW+1)'(1)))
		else $error("fifo count did not follow a write");
	COV_FIFO_FULL: cover property (cnt_r == (AW+1)'(DEPTH));
endmodule

module ddc_hb_stage
	import ddc_pkg::*;
#(
	parameter int K = 0
)(
	input  wire logic      clk_sys,
	input  wire logic      reset_n,
	input  wire logic      run,
	input  wire logic      in_vld,
	input  wire ddc_cplx_s in_dat,
	output logic           out_vld,
	output ddc_cplx_s      out_dat
);
	localparam int N  = DDC_STAGE_N[K];
	localparam int L  = 4 * N - 1;
	localparam int C  = 2 * N - 1;
	localparam int SH = DDC_STAGE_SHIFT[K];
	localparam int AW = DDC_ACC_W;

	ddc_cplx_s                   tap_r [L-1];
	ddc_cplx_s                   tap_nxt [L-1];
	logic signed [DDC_INT_W-1:0] wi [L];
	logic signed [DDC_INT_W-1:0] wq [L];
	logic                        phase_r, phase_nxt, vld_r, vld_nxt;
	ddc_cplx_s                   out_r, out_nxt;

	// only nonzero outer taps are multiplied, each pair folded first
	function automatic logic signed [DDC_INT_W-1:0] hb_fir(
		input logic signed [DDC_INT_W-1:0] w [L]);
		logic signed [AW-1:0] acc;
		int                   d;
		acc = AW'(w[C]) <<< (SH - 1);
		for (int k = 0; k < N; k++)
		begin
			d   = 2 * (N - k) - 1;
			acc = acc + AW'(DDC_STAGE_COEF[K][k]) * (AW'(w[C-d]) + AW'(w[C+d]));
		end
		acc = (acc + (AW'(1) <<< (SH - 1))) >>> SH;
		return acc[DDC_INT_W-1:0];
	endfunction

	assign out_vld = vld_r;
	assign out_dat = out_r;

	always_comb
	begin
		tap_nxt   = tap_r;
		phase_nxt = phase_r;
		vld_nxt   = vld_r;
		out_nxt   = out_r;
		wi[0]     = in_dat.i;
		wq[0]     = in_dat.q;
		for (int j = 1; j < L; j++)
		begin
			wi[j] = tap_r[j-1].i;
			wq[j] = tap_r[j-1].q;
		end
		if (run)
		begin
			vld_nxt = 1'b0;
			if (in_vld)
			begin
				tap_nxt[0] = in_dat;
				for (int j = 1; j < L - 1; j++)
					tap_nxt[j] = tap_r[j-1];
				phase_nxt = ~phase_r;
				if (phase_r)
				begin
					vld_nxt   = 1'b1;
					out_nxt.i = hb_fir(wi);
					out_nxt.q = hb_fir(wq);
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int j = 0; j < L - 1; j++)
				tap_r[j] <= '0;
			phase_r <= 1'b0;
			vld_r   <= 1'b0;
			out_r   <= '0;
		end
		else
		begin
			tap_r   <= tap_nxt;
			phase_r <= phase_nxt;
			vld_r   <= vld_nxt;
			out_r   <= out_nxt;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_HALF_RATE: assert property ((vld_r && run) |=> !vld_r)
		else $error("stage produced outputs on consecutive advances");
endmodule

module ddc_chain
	import ddc_pkg::*;
#(
	parameter int FIFO_DEPTH = DDC_FIFO_DEPTH
)(
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	input  wire logic [2:0]            link_mode_select,
	input  wire logic                  gain_boost,
	input  wire logic                  in_valid,
	output logic                       in_ready,
	input  wire logic [DDC_IN_W-1:0]   in_i,
	input  wire logic [DDC_IN_W-1:0]   in_q,
	input  wire logic [DDC_REAL_W-1:0] in_real,
	input  wire logic                  over_range_flag_a,
	input  wire logic                  over_range_flag_b,
	output logic                       out_valid,
	input  wire logic                  out_ready,
	output ddc_word_s                  out_word
);
	logic                  is_dec, run, accept, push;
	logic [DDC_NSTAGE-1:0] use_stage, vld_in, vld_out, st_vld;
	ddc_cplx_s             dat_in [DDC_NSTAGE];
	ddc_cplx_s             dat_out [DDC_NSTAGE];
	ddc_cplx_s             st_dat [DDC_NSTAGE];
	ddc_cplx_s             final_dat;
	ddc_word_s             push_word;
	logic                  ovr_a_r, ovr_a_nxt, ovr_b_r, ovr_b_nxt, seen_a, seen_b;

	// saturating round from the 16-bit input scale to 15 bits
	function automatic logic [DDC_OUT_W-1:0] to_out(input logic signed [DDC_INT_W:0] v);
		logic signed [DDC_INT_W:0] r;
		r = (v + (DDC_INT_W+1)'(1)) >>> 1;
		if (r > (DDC_INT_W+1)'(16383))
			return 15'h3fff;
		else if (r < -(DDC_INT_W+1)'(16384))
			return 15'h4000;
		return r[DDC_OUT_W-1:0];
	endfunction

	assign is_dec = (link_mode_select >= DDC_MODE_DEC4) && (link_mode_select <= DDC_MODE_DEC32);
	assign accept = in_valid && run;
	assign in_ready = run;
	assign vld_in[0] = accept && is_dec;
	assign dat_in[0] = '{i: DDC_INT_W'(signed'(in_i)), q: DDC_INT_W'(signed'(in_q))};

	genvar g;
	generate
		for (g = 0; g < DDC_NSTAGE; g++)
		begin : g_stage
			assign use_stage[g] = is_dec && (link_mode_select >= 3'(DDC_NSTAGE - 1 - g));
			ddc_hb_stage #(.K(g)) u_stage (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.run     (run),
				.in_vld  (vld_in[g] && use_stage[g]),
				.in_dat  (dat_in[g]),
				.out_vld (st_vld[g]),
				.out_dat (st_dat[g])
			);
			// an unused stage is passed around, keeping the fixed order
			assign vld_out[g] = use_stage[g] ? st_vld[g] : vld_in[g];
			assign dat_out[g] = use_stage[g] ? st_dat[g] : dat_in[g];
			if (g < DDC_NSTAGE - 1)
			begin : g_link
				assign vld_in[g+1] = vld_out[g];
				assign dat_in[g+1] = dat_out[g];
			end
			AST_UNUSED_IDLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
				(!use_stage[g] && run) |=> !st_vld[g])
				else $error("unused stage produced a sample");
		end
	endgenerate

	assign final_dat = dat_out[DDC_NSTAGE-1];
	assign seen_a = ovr_a_r || (accept && over_range_flag_a);
	assign seen_b = ovr_b_r || (accept && over_range_flag_b);

	always_comb
	begin
		push_word = '0;
		if (!is_dec)
		begin
			push = accept;
			push_word.i_word = {in_real, 3'h0, over_range_flag_a};
		end
		else
		begin
			push = run && vld_out[DDC_NSTAGE-1];
			push_word.i_word = {to_out(gain_boost ? {final_dat.i, 1'b0}
				: {final_dat.i[DDC_INT_W-1], final_dat.i}), seen_a};
			push_word.q_word = {to_out(gain_boost ? {final_dat.q, 1'b0}
				: {final_dat.q[DDC_INT_W-1], final_dat.q}), seen_b};
		end
	end

	// flags seen during one output period; a flag arriving on the push goes in that word
	always_comb
	begin
		// bypass clears on every word too, so no stale flag reaches the first decimated word
		ovr_a_nxt = push ? 1'b0 : seen_a;
		ovr_b_nxt = push ? 1'b0 : seen_b;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ovr_a_r <= 1'b0;
			ovr_b_r <= 1'b0;
		end
		else
		begin
			ovr_a_r <= ovr_a_nxt;
			ovr_b_r <= ovr_b_nxt;
		end
	end

	// a full fifo freezes the whole chain, so no decimated sample is dropped
	ddc_fifo #(.WIDTH($bits(ddc_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.wr_valid (push),
		.wr_ready (run),
		.wr_data  (push_word),
		.rd_valid (out_valid),
		.rd_ready (out_ready),
		.rd_data  (out_word)
	);

	// checking helpers: completed input groups owed an output; gaps in the input are legal,
	// and a mode change with samples already in the stages leaves their phases unknown
	logic [6:0] grp_cnt_r, grp_cnt_nxt;
	logic [1:0] owed_r, owed_nxt;
	logic       fresh_r, fresh_nxt, aligned_r, aligned_nxt;
	logic [2:0] mode_prev_r;
	logic [6:0] factor;
	logic       grp_done;
	assign factor   = 7'(DDC_BASE_FACT) << (link_mode_select - 3'h1);
	assign grp_done = accept && is_dec && (grp_cnt_r == factor - 7'h01);

	always_comb
	begin
		grp_cnt_nxt = grp_cnt_r;
		owed_nxt    = owed_r + 2'(grp_done) - 2'(push && is_dec);
		fresh_nxt   = fresh_r && !(accept && is_dec);
		aligned_nxt = aligned_r;
		if (accept && is_dec)
			grp_cnt_nxt = grp_done ? 7'h00 : grp_cnt_r + 7'h01;
		if (mode_prev_r != link_mode_select)
		begin
			grp_cnt_nxt = '0;
			owed_nxt    = '0;
			aligned_nxt = aligned_r && fresh_r;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			grp_cnt_r   <= '0;
			owed_r      <= '0;
			fresh_r     <= 1'b1;
			aligned_r   <= 1'b1;
			mode_prev_r <= '0;
		end
		else
		begin
			grp_cnt_r   <= grp_cnt_nxt;
			owed_r      <= owed_nxt;
			fresh_r     <= fresh_nxt;
			aligned_r   <= aligned_nxt;
			mode_prev_r <= link_mode_select;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_BYPASS_DIRECT: assert property ((!is_dec && accept) |->
		push && (push_word.i_word[15:4] == in_real) && (push_word.q_word == 16'h0000))
		else $error("bypass sample not passed straight through");
	AST_DEC_RATIO: assert property ((is_dec && push && aligned_r) |-> (owed_r != 2'h0))
		else $error("decimated output without a full input group");
	AST_DEC_OWED: assert property ((is_dec && aligned_r) |-> (owed_r <= 2'h1))
		else $error("decimated output missing for a full input group");
	AST_STALL_HOLD: assert property ((is_dec && !run) |=>
		$stable(vld_out[DDC_NSTAGE-1]) && $stable(final_dat))
		else $error("pending output lost during stall");
	AST_OVR_LSB: assert property ((is_dec && push) |->
		(push_word.i_word[0] == seen_a) && (push_word.q_word[0] == seen_b) ##1 !ovr_a_r)
		else $error("over-range flag not carried in bit 0");
	AST_BOOST: assert property ((is_dec && push && gain_boost && final_dat.i < 18'sd16384
		&& final_dat.i >= -18'sd16384) |-> ($signed(push_word.i_word[15:1]) == final_dat.i))
		else $error("boosted output does not double the gain");
	COV_DEC32: cover property (push && link_mode_select == DDC_MODE_DEC32 && aligned_r);
	COV_BYPASS: cover property (push && !is_dec);
	COV_STALL: cover property (is_dec && !run);
endmodule

`default_nettype wire

// file: hdl/ddc_pkg.sv
package ddc_pkg;

	localparam int DDC_IN_W       = 16;
	localparam int DDC_INT_W      = 18;
	localparam int DDC_OUT_W      = 15;
	localparam int DDC_REAL_W     = 12;
	localparam int DDC_NSTAGE     = 5;
	localparam int DDC_MAX_TAPS   = 14;
	localparam int DDC_FIFO_DEPTH = 8;
	localparam int DDC_ACC_W      = DDC_INT_W + 24;
	localparam int DDC_BASE_FACT  = 4;

	typedef enum logic [2:0] {
		DDC_MODE_BYPASS,
		DDC_MODE_DEC4,
		DDC_MODE_DEC8,
		DDC_MODE_DEC16,
		DDC_MODE_DEC32
	} ddc_mode_e;

	// stage index 0 is the first stage applied, 4 the last
	localparam int DDC_STAGE_N [DDC_NSTAGE]     = '{2, 2, 3, 4, 14};
	localparam int DDC_STAGE_SHIFT [DDC_NSTAGE] = '{5, 11, 14, 17, 19};
	// outer half of each symmetric set, outermost tap first; centre is 2**(shift-1)
	localparam int DDC_STAGE_COEF [DDC_NSTAGE][DDC_MAX_TAPS] = '{
		'{-1, 9, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{-65, 577, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{109, -837, 4824, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{-327, 2231, -8881, 39742, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{-37, 118, -291, 612, -1159, 2031, -3356, 5308, -8140, 12284, -18628, 29455,
			-53191, 166059}
	};

	typedef struct packed {
		logic signed [DDC_INT_W-1:0] i;
		logic signed [DDC_INT_W-1:0] q;
	} ddc_cplx_s;

	typedef struct packed {
		logic [15:0] i_word;
		logic [15:0] q_word;
	} ddc_word_s;

endpackage

// file: tb/ddc_framer_model.sv
`timescale 1ns/100ps
`default_nettype none

// downstream consumer: prompt, stalled, or randomly slow
module ddc_framer_model (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic stall,
	input  wire logic slow,
	output logic      out_ready
);
	logic coin_r;

	// coin flips off the sampling edge so ready never races the pop
	always @(negedge clk_sys)
		coin_r <= 1'($urandom_range(0, 1));

	assign out_ready = reset_n && !stall && (!slow || coin_r);
endmodule

`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import ddc_pkg::*;

	logic                  clk_sys           = 1'b0;
	logic                  reset_n           = 1'b0;
	logic [2:0]            link_mode_select  = 3'h0;
	logic                  gain_boost        = 1'b0;
	logic                  in_valid          = 1'b0;
	logic [DDC_IN_W-1:0]   in_i              = 16'h0;
	logic [DDC_IN_W-1:0]   in_q              = 16'h0;
	logic [DDC_REAL_W-1:0] in_real           = 12'h0;
	logic                  over_range_flag_a = 1'b0;
	logic                  over_range_flag_b = 1'b0;
	logic                  stall             = 1'b0;
	logic                  slow              = 1'b0;
	logic                  in_ready;
	logic                  out_valid;
	logic                  out_ready;
	ddc_word_s             out_word;
	int                    errors            = 0;
	int                    comparisons       = 0;
	logic [31:0]           exp_q [$];
	bit                    mask_q [$];
	logic [31:0]           exp_w;
	bit                    exp_m;

	always #25 clk_sys = ~clk_sys;

	ddc_chain u_dut (
		.clk_sys           (clk_sys),
		.reset_n           (reset_n),
		.link_mode_select  (link_mode_select),
		.gain_boost        (gain_boost),
		.in_valid          (in_valid),
		.in_ready          (in_ready),
		.in_i              (in_i),
		.in_q              (in_q),
		.in_real           (in_real),
		.over_range_flag_a (over_range_flag_a),
		.over_range_flag_b (over_range_flag_b),
		.out_valid         (out_valid),
		.out_ready         (out_ready),
		.out_word          (out_word)
	);

	ddc_framer_model u_framer (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.stall     (stall),
		.slow      (slow),
		.out_ready (out_ready)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// early decimated words carry the filter transient, so they are counted but not compared
	always @(posedge clk_sys)
		if (reset_n && out_valid === 1'b1 && out_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unexpected word", 32'h1, 32'h0);
			else
			begin
				exp_w = exp_q.pop_front();
				exp_m = mask_q.pop_front();
				if (exp_m)
					check("out_word", out_word, exp_w);
			end
		end

	task automatic do_reset();
		@(negedge clk_sys);
		in_valid = 1'b0;
		reset_n  = 1'b0;
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
	endtask

	// holds the sample from a falling edge until the rising edge that takes it
	task automatic send(input logic [15:0] i, input logic [15:0] q, input logic [11:0] r,
		input logic a, input logic b);
		int n;
		@(negedge clk_sys);
		in_valid          = 1'b1;
		in_i              = i;
		in_q              = q;
		in_real           = r;
		over_range_flag_a = a;
		over_range_flag_b = b;
		n = 0;
		while (in_ready !== 1'b1 && n < 300)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 300)
			check("in_ready wait", 32'h0, 32'h1);
		@(posedge clk_sys);
	endtask

	task automatic drain(input string name);
		int n;
		@(negedge clk_sys);
		in_valid = 1'b0;
		n = 0;
		while (exp_q.size() != 0 && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
		check("words left", 32'(exp_q.size()), 32'h0);
		repeat (30) @(negedge clk_sys);
		$display("test %s done", name);
	endtask

	initial
	begin
		#(30000 * 50);
		check("watchdog", 32'h0, 32'h1);
		end_of_test();
	end

	initial
	begin
		logic [11:0] r;
		logic        a;
		logic        b;
		logic [15:0] x;
		logic [15:0] y;
		int          f;
		void'($urandom(36));
		do_reset();
		slow = 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			// the mode moves to an undecoded bypass code off the sampling edge
			if (k == 20)
			begin
				@(negedge clk_sys);
				in_valid         = 1'b0;
				link_mode_select = 3'h7;
			end
			r = 12'($urandom);
			a = 1'($urandom);
			b = 1'($urandom);
			send(16'($urandom), 16'($urandom), r, a, b);
			exp_q.push_back({r, 3'h0, a, 16'h0});
			mask_q.push_back(1'b1);
		end
		drain("bypass");
		stall = 1'b1;
		repeat (DDC_FIFO_DEPTH)
		begin
			r = 12'($urandom);
			send(16'h0, 16'h0, r, 1'b0, 1'b0);
			exp_q.push_back({r, 4'h0, 16'h0});
			mask_q.push_back(1'b1);
		end
		@(negedge clk_sys);
		in_valid = 1'b0;
		check("in_ready when full", 32'(in_ready), 32'h0);
		stall = 1'b0;
		drain("fifo full");
		for (int m = 1; m <= 4; m++)
		begin
			do_reset();
			link_mode_select = 3'(m);
			gain_boost       = m[0];
			slow             = m[1];
			f = DDC_BASE_FACT << (m - 1);
			// even dc levels keep the unboosted halving exact
			x = 16'(2 * $urandom_range(0, 8000) - 8000);
			y = 16'(2 * $urandom_range(0, 8000) - 8000);
			for (int k = 1; k <= 48 * f; k++)
			begin
				if (k == 8 * f)
				begin
					// a stalled framer fills the fifo and freezes the chain for a while
					fork
					begin
						@(negedge clk_sys);
						stall = 1'b1;
						repeat (12 * f) @(negedge clk_sys);
						stall = 1'b0;
					end
					join_none
				end
				send(x, y, 12'h0, m[0], ~m[0]);
				if (k % f == 0)
				begin
					exp_q.push_back({gain_boost ? x[14:0] : x[15:1], 1'(m[0]),
						gain_boost ? y[14:0] : y[15:1], 1'(~m[0])});
					mask_q.push_back(k / f > 40);
				end
			end
			drain($sformatf("decimate by %0d", f));
		end
		end_of_test();
	end
endmodule

`default_nettype wire
